// file: design/sia_pkg.sv
// Purpose: constants and carriers for the sensor interrupt and indirect access slice
// Assumes: byte-wide register port from the control-bus slave on core_clk
// Notes: offsets are byte addresses on the control bus
package sia_pkg;
    localparam logic [7:0] SIA_RISE_MASK_OFS = 8'h7E;
    localparam logic [7:0] SIA_FALL_MASK_OFS = 8'h7F;
    localparam logic [7:0] SIA_RSVD_A0_OFS = 8'hA0;
    localparam logic [7:0] SIA_REFCLK_OFS = 8'hA5;
    localparam logic [7:0] SIA_RSVD_A7_OFS = 8'hA7;
    localparam logic [7:0] SIA_IND_CTL_OFS = 8'hB0;
    localparam logic [7:0] SIA_IND_OFFSET_OFS = 8'hB1;
    localparam logic [7:0] SIA_IND_WINDOW_OFS = 8'hB2;

    localparam logic [7:0] SIA_MASK_RST = 8'h00;
    localparam logic [7:0] SIA_REFCLK_RST = 8'h00;
    localparam logic [7:0] SIA_OFFSET_RST = 8'h00;
    localparam logic [3:0] SIA_TARGET_RST = 4'h0;
    localparam logic [7:0] SIA_OFFSET_STEP = 8'h01;

    // control register field positions
    localparam int SIA_PREFETCH_BIT = 0;
    localparam int SIA_AUTOSTEP_BIT = 1;
    localparam int SIA_TARGET_LSB = 2;
    localparam int SIA_TARGET_MSB = 5;

    // indirect target codes
    localparam logic [3:0] SIA_TGT_PATGEN = 4'h0;
    localparam logic [3:0] SIA_TGT_RX0 = 4'h1;
    localparam logic [3:0] SIA_TGT_RX1 = 4'h2;
    localparam logic [3:0] SIA_TGT_RX_SHARED = 4'h5;
    localparam logic [3:0] SIA_TGT_RX_BOTH = 4'h6;
    localparam logic [3:0] SIA_TGT_OUTPUT = 4'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sia_reg_req_t;

    typedef struct packed {
        logic wr_stb;
        logic rd_stb;
        logic [1:0] rx_wr_mask;
        logic [3:0] target;
        logic [7:0] offset;
        logic [7:0] wdata;
    } sia_ind_req_t;
endpackage

// file: design/sia_regs.sv
// Purpose: per-port sensor edge interrupt masks, refclk rate readout, indirect access port
// Assumes: reg_req is one-cycle strobes on core_clk; port select comes from the hub's select reg
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/10ps
module sia_regs
    import sia_pkg::*;
#(
    parameter int NPORTS = 2
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire sia_reg_req_t reg_req,
    input wire logic [NPORTS-1:0] port_wr_mask,
    input wire logic port_rd_sel,
    input wire logic [NPORTS-1:0][7:0] sensor_status_bits,
    input wire logic [NPORTS-1:0][7:0] rise_clear,
    input wire logic [NPORTS-1:0][7:0] fall_clear,
    input wire logic [7:0] refclk_rate_meas,
    input wire logic [7:0] ind_rdata,
    output logic [7:0] reg_rdata_q,
    output logic [NPORTS-1:0][7:0] rise_edge_latched_status,
    output logic [NPORTS-1:0][7:0] fall_edge_latched_status,
    output sia_ind_req_t ind_req_q
);
    logic [NPORTS-1:0][7:0] rise_edge_mask;
    logic [NPORTS-1:0][7:0] fall_edge_mask;
    logic [NPORTS-1:0][7:0] sts_meta_q;
    logic [NPORTS-1:0][7:0] sts_sync_q;
    logic [NPORTS-1:0][7:0] sts_prev_q;
    logic [NPORTS-1:0][7:0] rise_ev;
    logic [NPORTS-1:0][7:0] fall_ev;
    logic [NPORTS-1:0][7:0] rise_keep;
    logic [7:0] reference_clock_rate;
    logic indirect_prefetch_enable;
    logic indirect_offset_autostep;
    logic [7:0] rdata_d;
    logic wr_ctl;
    logic wr_ofs;
    logic wr_win;
    logic rd_win;

    assign wr_ctl = reg_req.wr && reg_req.addr == SIA_IND_CTL_OFS;
    assign wr_ofs = reg_req.wr && reg_req.addr == SIA_IND_OFFSET_OFS;
    assign wr_win = reg_req.wr && reg_req.addr == SIA_IND_WINDOW_OFS;
    assign rd_win = reg_req.rd && reg_req.addr == SIA_IND_WINDOW_OFS;

    genvar p;
    generate
        for (p = 0; p < NPORTS; p++) begin : g_port
            // status comes from the link side, so two flops before any edge logic
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    sts_meta_q[p] <= 8'h00;
                    sts_sync_q[p] <= 8'h00;
                    sts_prev_q[p] <= 8'h00;
                end else begin
                    sts_meta_q[p] <= sensor_status_bits[p];
                    sts_sync_q[p] <= sts_meta_q[p];
                    sts_prev_q[p] <= sts_sync_q[p];
                end
            end

            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    rise_edge_mask[p] <= SIA_MASK_RST;
                    fall_edge_mask[p] <= SIA_MASK_RST;
                end else if (reg_req.wr && port_wr_mask[p]) begin
                    if (reg_req.addr == SIA_RISE_MASK_OFS) begin
                        rise_edge_mask[p] <= reg_req.wdata;
                    end
                    if (reg_req.addr == SIA_FALL_MASK_OFS) begin
                        fall_edge_mask[p] <= reg_req.wdata;
                    end
                end
            end

            assign rise_ev[p] = sts_sync_q[p] & ~sts_prev_q[p] & rise_edge_mask[p];
            assign fall_ev[p] = ~sts_sync_q[p] & sts_prev_q[p] & fall_edge_mask[p];
            assign rise_keep[p] = rise_edge_latched_status[p] & ~rise_clear[p];

            // a new edge wins over a clear in the same cycle
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    rise_edge_latched_status[p] <= 8'h00;
                    fall_edge_latched_status[p] <= 8'h00;
                end else begin
                    rise_edge_latched_status[p] <= rise_keep[p] | rise_ev[p];
                    fall_edge_latched_status[p] <=
                        (fall_edge_latched_status[p] & ~fall_clear[p]) | fall_ev[p];
                end
            end

            rise_latch_a: assert property (@(posedge core_clk) disable iff (!rstn)
                (rise_ev[p] != 8'h00) |=>
                ((rise_edge_latched_status[p] & $past(rise_ev[p])) == $past(rise_ev[p])))
                else $error("rise edge not latched");
            fall_latch_a: assert property (@(posedge core_clk) disable iff (!rstn)
                (fall_ev[p] != 8'h00) |=>
                ((fall_edge_latched_status[p] & $past(fall_ev[p])) == $past(fall_ev[p])))
                else $error("fall edge not latched");
            sticky_status_a: assert property (@(posedge core_clk) disable iff (!rstn)
                1'b1 |=>
                ((rise_edge_latched_status[p] & $past(rise_keep[p])) == $past(rise_keep[p])))
                else $error("latched bit lost without clear");
            port_isolate_a: assert property (@(posedge core_clk) disable iff (!rstn)
                (!port_wr_mask[p]) |=> $stable(rise_edge_mask[p]) && $stable(fall_edge_mask[p]))
                else $error("mask of unselected port changed");
        end
    endgenerate

    // plain capture; host double-reads because this is not held for the read path
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reference_clock_rate <= SIA_REFCLK_RST;
        end else begin
            reference_clock_rate <= refclk_rate_meas;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ind_req_q.target <= SIA_TARGET_RST;
            indirect_offset_autostep <= 1'b0;
            indirect_prefetch_enable <= 1'b0;
        end else if (wr_ctl) begin
            ind_req_q.target <= reg_req.wdata[SIA_TARGET_MSB:SIA_TARGET_LSB];
            indirect_offset_autostep <= reg_req.wdata[SIA_AUTOSTEP_BIT];
            indirect_prefetch_enable <= reg_req.wdata[SIA_PREFETCH_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ind_req_q.offset <= SIA_OFFSET_RST;
        end else if (wr_ofs) begin
            ind_req_q.offset <= reg_req.wdata;
        end else if ((wr_win || rd_win) && indirect_offset_autostep) begin
            ind_req_q.offset <= ind_req_q.offset + SIA_OFFSET_STEP;
        end
    end

    // strobes use the offset of the same edge, so a prefetch sees the new offset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ind_req_q.wr_stb <= 1'b0;
            ind_req_q.rd_stb <= 1'b0;
            ind_req_q.rx_wr_mask <= 2'h0;
            ind_req_q.wdata <= 8'h00;
        end else begin
            ind_req_q.wr_stb <= wr_win;
            ind_req_q.rd_stb <= indirect_prefetch_enable &&
                (wr_ofs || (rd_win && indirect_offset_autostep));
            if (wr_win) begin
                ind_req_q.wdata <= reg_req.wdata;
            end
            case (ind_req_q.target)
                SIA_TGT_RX0: ind_req_q.rx_wr_mask <= {1'b0, wr_win};
                SIA_TGT_RX1: ind_req_q.rx_wr_mask <= {wr_win, 1'b0};
                SIA_TGT_RX_BOTH: ind_req_q.rx_wr_mask <= {wr_win, wr_win};
                default: ind_req_q.rx_wr_mask <= 2'h0;
            endcase
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        case (reg_req.addr)
            SIA_RISE_MASK_OFS: rdata_d = rise_edge_mask[port_rd_sel];
            SIA_FALL_MASK_OFS: rdata_d = fall_edge_mask[port_rd_sel];
            SIA_REFCLK_OFS: rdata_d = reference_clock_rate;
            SIA_IND_CTL_OFS: rdata_d = {2'b00, ind_req_q.target,
                indirect_offset_autostep, indirect_prefetch_enable};
            SIA_IND_OFFSET_OFS: rdata_d = ind_req_q.offset;
            SIA_IND_WINDOW_OFS: rdata_d = ind_rdata;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_req.rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    refclk_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == SIA_REFCLK_OFS) |=>
        reg_rdata_q == $past(reference_clock_rate))
        else $error("refclk read mismatch");
    ctl_reserved_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == SIA_IND_CTL_OFS) |=> reg_rdata_q[7:6] == 2'b00)
        else $error("reserved control bits not zero");
    target_store_a: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_ctl |=> ind_req_q.target == $past(reg_req.wdata[5:2]))
        else $error("target select not stored");
    both_ports_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_win && ind_req_q.target == SIA_TGT_RX_BOTH) |=>
        ind_req_q.wr_stb && ind_req_q.rx_wr_mask == 2'b11)
        else $error("broadcast write missing");
    offset_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ((wr_win || rd_win) && !wr_ofs && indirect_offset_autostep) |=>
        ind_req_q.offset == 8'($past(ind_req_q.offset) + 8'h01))
        else $error("offset not stepped");
    prefetch_ofs_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_ofs && indirect_prefetch_enable) |=>
        ind_req_q.rd_stb && ind_req_q.offset == $past(reg_req.wdata))
        else $error("no prefetch on offset write");
    prefetch_win_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (rd_win && indirect_prefetch_enable && indirect_offset_autostep) |=> ind_req_q.rd_stb)
        else $error("no prefetch on window read");
    window_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_win |=> reg_rdata_q == $past(ind_rdata) && !ind_req_q.wr_stb)
        else $error("window read data wrong");
endmodule

// file: sim/sia_host.sv
// Purpose: host model issuing register reads and writes
// Assumes: requests launched 1 ns after the rising edge
// Notes: stands in for the control-bus master
`timescale 1ns/10ps
module sia_host
    import sia_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] rdata,
    output sia_reg_req_t req
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1 req = '{1'h1, 1'h0, a, d};
        @(posedge core_clk) #1 req = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) #1 req = '{1'h0, 1'h1, a, 8'h00};
        @(posedge core_clk) #1 req = '0;
        d = rdata;
    endtask
    // rate is unsynchronized, so only two equal reads are trusted
    task automatic rate(output logic [7:0] d, output logic ok);
        logic [7:0] d2;
        rd(SIA_REFCLK_OFS, d);
        rd(SIA_REFCLK_OFS, d2);
        ok = (d === d2);
    endtask
endmodule

// file: sim/sia_regs_tb.sv
// Purpose: self-checking bench for sia_regs
// Assumes: two receive ports, host model drives the register port
// Notes: table rows first, then port select, edges, indirect, reset
`timescale 1ns/10ps
module sia_regs_tb;
    import sia_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sia_row_t;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    sia_reg_req_t req;
    logic [1:0] pwm = 2'h1;
    logic prs = 1'h0;
    logic [1:0][7:0] sts = '0;
    logic [1:0][7:0] rclr = '0;
    logic [1:0][7:0] fclr = '0;
    logic [7:0] refclk = 8'h32;
    logic [7:0] ird = 8'h9A;
    logic [7:0] rdata, v;
    logic [1:0][7:0] rise, fall;
    logic [1:0] m;
    logic ok;
    sia_ind_req_t ind;
    int mismatches = 0;
    int checks = 0;
    sia_row_t rows [7] = '{'{8'h7E, 8'hA5, 8'hA5}, '{8'h7F, 8'h3C, 8'h3C},
        '{8'hB0, 8'hFF, 8'h3F}, '{8'hB1, 8'h80, 8'h80}, '{8'hA0, 8'hFF, 8'h00},
        '{8'hA7, 8'hFF, 8'h00}, '{8'hA5, 8'hFF, 8'h32}};

    sia_regs uut (.core_clk(core_clk), .rstn(rstn), .reg_req(req), .port_wr_mask(pwm),
        .port_rd_sel(prs), .sensor_status_bits(sts), .rise_clear(rclr), .fall_clear(fclr),
        .refclk_rate_meas(refclk), .ind_rdata(ird), .reg_rdata_q(rdata),
        .rise_edge_latched_status(rise), .fall_edge_latched_status(fall), .ind_req_q(ind));
    sia_host host (.core_clk(core_clk), .rdata(rdata), .req(req));

    always #5 core_clk = ~core_clk;

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // generous span: the whole sequence needs well under 1000 cycles
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        #1 rstn = 1'h1;
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, v);
            chk("row", {8'h00, rows[i].e}, {8'h00, v});
        end
        host.wr(SIA_RISE_MASK_OFS, 8'h11);
        pwm = 2'h2;
        host.wr(SIA_RISE_MASK_OFS, 8'h22);
        prs = 1'h1;
        host.rd(SIA_RISE_MASK_OFS, v);
        chk("mask port 1", 16'h0022, {8'h00, v});
        prs = 1'h0;
        host.rd(SIA_RISE_MASK_OFS, v);
        chk("mask port 0", 16'h0011, {8'h00, v});
        pwm = 2'h3;
        host.wr(SIA_RISE_MASK_OFS, 8'h0F);
        host.wr(SIA_FALL_MASK_OFS, 8'hF0);
        sts = '1;
        repeat (4) @(posedge core_clk);
        #1 chk("rise", 16'h0F0F, rise);
        chk("fall quiet", 16'h0000, fall);
        sts = '0;
        repeat (4) @(posedge core_clk);
        #1 chk("fall", 16'hF0F0, fall);
        chk("rise held", 16'h0F0F, rise);
        rclr = '1;
        fclr = '1;
        @(posedge core_clk) #1 rclr = '0;
        fclr = '0;
        @(posedge core_clk) #1 chk("cleared", 16'h0000, rise | fall);
        // clear held high on the very edge that latches a new rise: set must win
        sts = '1;
        repeat (2) @(posedge core_clk);
        #1 rclr = '1;
        @(posedge core_clk) #1 chk("set beats clear", 16'h0F0F, rise);
        rclr = '0;
        // prefetch chosen because the target must fetch before reads
        host.wr(SIA_IND_CTL_OFS, 8'h1B);
        host.wr(SIA_IND_OFFSET_OFS, 8'hFF);
        chk("prefetch", 16'h01FF, {7'h0, ind.rd_stb, ind.offset});
        host.wr(SIA_IND_WINDOW_OFS, 8'h55);
        chk("wr strobe", 16'h0103, {7'h0, ind.wr_stb, 6'h0, ind.rx_wr_mask});
        chk("wdata wrap", 16'h5500, {ind.wdata, ind.offset});
        host.rd(SIA_IND_WINDOW_OFS, v);
        chk("window", 16'h9A01, {v, ind.offset});
        chk("rd strobe", 16'h0001, {15'h0, ind.rd_stb});
        for (int c = 0; c < 16; c++) begin
            m = (c == 1) ? 2'h1 : (c == 2) ? 2'h2 : (c == 6) ? 2'h3 : 2'h0;
            host.wr(SIA_IND_CTL_OFS, {2'h0, c[3:0], 2'h0});
            host.wr(SIA_IND_WINDOW_OFS, 8'h00);
            chk("target", {c[3:0], 2'h0, m, 8'h01},
                {ind.target, 2'h0, ind.rx_wr_mask, ind.offset});
        end
        refclk = 8'h47;
        host.rate(v, ok);
        chk("refclk", 16'h0147, {7'h0, ok, v});
        rstn = 1'h0;
        repeat (2) @(posedge core_clk);
        #1 rstn = 1'h1;
        for (int i = 0; i < 4; i++) begin
            host.rd(rows[i].a, v);
            chk("reset value", 16'h0000, {v, ind.offset});
        end
        stop_test();
    end
endmodule
